/* File: core/fsi_pkg.sv */
// constants, types and helpers shared by the streaming port logic
// Operation
// - every element runs from the single clock; both ports are synchronous to it
// - error code: 00 none, 01 missing start, 10 missing end, 11 early end
// - input ready is high whenever a sample can be accepted; source may idle
// - an input transfer happens exactly when input valid and input ready are high
// - output start and end markers flag first and last results, only when valid; the code holds their last values while output valid is low
// - output error is input error ORed with internally detected errors
// - a six-bit signed block exponent records net scaling of each frame; the code always outputs EXP_NONE (zero)
// - output width equals input width except fixed-point variable streaming
// - fixed-point variable streaming widens outputs two bits per radix-2-squared stage
// - output valid is high exactly when the output fields hold a valid result
// - detect missing start, missing end after a full frame, and early end
// - direction input is sampled with the start marker; high selects inverse
// - clock enable low suspends operation; high resumes it
package fsi_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int DATA_W     = 16;
   localparam int EXP_W      = 6;
   localparam int ERR_W      = 2;
   localparam int FRAME_LEN  = 64;
   localparam int CNT_W      = 6;
   localparam int FIFO_DEPTH = 16;
   localparam int LVL_W      = 5;
   localparam int R22_STAGES = 3;

   typedef enum logic [2:0] {
      FSI_ARCH_STREAM,
      FSI_ARCH_BURST,
      FSI_ARCH_BUF_BURST,
      FSI_ARCH_VAR_FIXED,
      FSI_ARCH_VAR_FLOAT
   } fsi_arch_t;

   localparam fsi_arch_t ARCH = FSI_ARCH_STREAM;
   localparam int GROWTH = (ARCH == FSI_ARCH_VAR_FIXED) ? 2 * R22_STAGES : 0;
   localparam int OUT_W  = DATA_W + GROWTH;

   // ---------------------------------------------------------------
   // error codes, exponent reset value and last frame count
   // ---------------------------------------------------------------
   localparam logic [ERR_W-1:0] ERR_NONE      = 2'h0;
   localparam logic [ERR_W-1:0] ERR_NO_SOP    = 2'h1;
   localparam logic [ERR_W-1:0] ERR_NO_EOP    = 2'h2;
   localparam logic [ERR_W-1:0] ERR_EARLY_EOP = 2'h3;
   localparam logic [EXP_W-1:0] EXP_NONE      = 6'h00;
   localparam logic [CNT_W-1:0] CNT_LAST      = 6'h3f;

   // ---------------------------------------------------------------
   // buffered word layout
   // ---------------------------------------------------------------
   localparam int W_REAL_LSB = 0;
   localparam int W_IMAG_LSB = DATA_W;
   localparam int W_SOP      = 2 * DATA_W;
   localparam int W_EOP      = W_SOP + 1;
   localparam int W_ERR_LSB  = W_SOP + 2;
   localparam int W_INV      = W_SOP + 4;
   localparam int WORD_W     = W_SOP + 5;

   // sign extension to the output width
   function automatic logic [OUT_W-1:0] fsi_widen(input logic [DATA_W-1:0] v);
      return OUT_W'($signed(v));
   endfunction

endpackage

/* File: core/fsi_fifo.sv */
// sample buffer with valid/ready on both sides
`timescale 1ns/1ps
module fsi_fifo #(
   parameter int W     = 37,
   parameter int DEPTH = 16,
   parameter int LW    = 5
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          en,
   input  wire logic          in_valid,
   output      logic          in_ready,
   input  wire logic [W-1:0]  in_data,
   output      logic          out_valid,
   input  wire logic          out_ready,
   output      logic [W-1:0]  out_data,
   output      logic [LW-1:0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [LW-1:0] lvl_q, lvl_d;
   logic          push, pop;

   assign in_ready  = (lvl_q != LW'(DEPTH));
   assign out_valid = (lvl_q != '0);
   assign out_data  = mem[rd_q];
   assign level     = lvl_q;
   assign push      = en & in_valid & in_ready;
   assign pop       = en & out_valid & out_ready;

   always_comb
   begin
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      lvl_d = lvl_q + LW'(push) - LW'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         lvl_q <= '0;
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         lvl_q <= lvl_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end
endmodule // fsi_fifo

/* File: core/fsi_frame_chk.sv */
// framing checker for the incoming sample stream
`timescale 1ns/1ps
module fsi_frame_chk (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      en,
   input  wire logic                      valid,
   input  wire logic                      ready,
   input  wire logic                      sop,
   input  wire logic                      eop,
   output      logic [fsi_pkg::ERR_W-1:0] beat_err,
   output      logic [fsi_pkg::ERR_W-1:0] err_q
);
   typedef enum logic {CHK_IDLE, CHK_FRAME} fsi_chk_t;

   fsi_chk_t                   state_q, state_d;
   logic [fsi_pkg::CNT_W-1:0]  cnt_q, cnt_d;
   logic [fsi_pkg::ERR_W-1:0]  err_d;
   logic                       beat;

   assign beat = en & valid & ready;

   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      beat_err = fsi_pkg::ERR_NONE;
      case (state_q)
         CHK_IDLE:
         begin
            if (en & valid & ~sop)
               beat_err = fsi_pkg::ERR_NO_SOP;
            if (beat & sop)
            begin
               cnt_d = 6'h01;
               if (eop)
                  beat_err = fsi_pkg::ERR_EARLY_EOP;
               else
                  state_d = CHK_FRAME;
            end
         end
         CHK_FRAME:
         begin
            if (beat)
            begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == fsi_pkg::CNT_LAST)
               begin
                  state_d = CHK_IDLE;
                  if (~eop)
                     beat_err = fsi_pkg::ERR_NO_EOP;
               end
               else if (eop)
               begin
                  state_d  = CHK_IDLE;
                  beat_err = fsi_pkg::ERR_EARLY_EOP;
               end
            end
         end
         default:
            state_d = CHK_IDLE;
      endcase
      // sticky: after a fault only a reset brings the core back to a known state
      err_d = err_q | beat_err;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= CHK_IDLE;
         cnt_q   <= '0;
         err_q   <= fsi_pkg::ERR_NONE;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         err_q   <= err_d;
      end
   end
endmodule // fsi_frame_chk

/* File: core/fsi_top.sv */
// streaming sink and source ports of the transform core
`timescale 1ns/1ps
module fsi_top (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_ena,
   input  wire logic                       inverse,
   input  wire logic                       sink_valid,
   output      logic                       sink_ready,
   input  wire logic [fsi_pkg::DATA_W-1:0] sink_real,
   input  wire logic [fsi_pkg::DATA_W-1:0] sink_imag,
   input  wire logic                       sink_sop,
   input  wire logic                       sink_eop,
   input  wire logic [fsi_pkg::ERR_W-1:0]  sink_error,
   output      logic                       source_valid,
   input  wire logic                       source_ready,
   output      logic [fsi_pkg::OUT_W-1:0]  source_real,
   output      logic [fsi_pkg::OUT_W-1:0]  source_imag,
   output      logic [fsi_pkg::EXP_W-1:0]  source_exp,
   output      logic                       source_sop,
   output      logic                       source_eop,
   output      logic [fsi_pkg::ERR_W-1:0]  source_error
);
   // ---------------------------------------------------------------
   // enable and sink side
   // ---------------------------------------------------------------
   logic                          en_q, en_d;
   logic                          ready_q, ready_d;
   logic                          inv_q, inv_d;
   logic                          beat;
   logic                          word_inv;
   logic [fsi_pkg::ERR_W-1:0]     beat_err;
   logic [fsi_pkg::ERR_W-1:0]     chk_err_q;
   logic [fsi_pkg::WORD_W-1:0]    in_word;
   logic                          fifo_in_ready;
   logic                          fifo_out_valid;
   logic [fsi_pkg::WORD_W-1:0]    head;
   logic [fsi_pkg::LVL_W-1:0]     level;
   logic [fsi_pkg::LVL_W:0]       lvl_next;
   logic                          pop;

   // ready is a flop, so it looks one cycle ahead at the fill level
   assign beat     = en_q & sink_valid & ready_q;
   assign word_inv = sink_sop ? inverse : inv_q;
   assign in_word  = {word_inv, sink_error | beat_err, sink_eop, sink_sop,
                      sink_imag, sink_real};

   always_comb
   begin
      en_d     = clk_ena;
      inv_d    = (beat & sink_sop) ? inverse : inv_q;
      lvl_next = (fsi_pkg::LVL_W+1)'(level) + (fsi_pkg::LVL_W+1)'(beat & fifo_in_ready)
               - (fsi_pkg::LVL_W+1)'(pop);
      ready_d  = clk_ena & (lvl_next <= (fsi_pkg::LVL_W+1)'(fsi_pkg::FIFO_DEPTH - 2));
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         en_q    <= 1'b0;
         ready_q <= 1'b0;
         inv_q   <= 1'b0;
      end
      else
      begin
         en_q    <= en_d;
         ready_q <= ready_d;
         inv_q   <= inv_d;
      end
   end

   assign sink_ready = ready_q;

   fsi_frame_chk u_chk (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .en       (en_q),
      .valid    (sink_valid),
      .ready    (ready_q),
      .sop      (sink_sop),
      .eop      (sink_eop),
      .beat_err (beat_err),
      .err_q    (chk_err_q)
   );

   fsi_fifo #(
      .W     (fsi_pkg::WORD_W),
      .DEPTH (fsi_pkg::FIFO_DEPTH),
      .LW    (fsi_pkg::LVL_W)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .en        (en_q),
      .in_valid  (beat),
      .in_ready  (fifo_in_ready),
      .in_data   (in_word),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (head),
      .level     (level)
   );

   // ---------------------------------------------------------------
   // source side
   // ---------------------------------------------------------------
   logic                          val_q, val_d;
   logic [fsi_pkg::OUT_W-1:0]     re_q, re_d, im_q, im_d;
   logic [fsi_pkg::EXP_W-1:0]     exp_q, exp_d;
   logic                          sop_q, sop_d, eop_q, eop_d;
   logic [fsi_pkg::ERR_W-1:0]     err_q, err_d;
   logic [fsi_pkg::DATA_W-1:0]    h_re, h_im;
   logic                          h_inv;

   assign h_re  = head[fsi_pkg::W_REAL_LSB +: fsi_pkg::DATA_W];
   assign h_im  = head[fsi_pkg::W_IMAG_LSB +: fsi_pkg::DATA_W];
   assign h_inv = head[fsi_pkg::W_INV];
   // load only into an empty or departing output register
   assign pop   = en_q & fifo_out_valid & (~val_q | source_ready);

   always_comb
   begin
      val_d = val_q;
      re_d  = re_q;
      im_d  = im_q;
      exp_d = exp_q;
      sop_d = sop_q;
      eop_d = eop_q;
      err_d = err_q;
      // a completed transfer is honoured even while suspended, to avoid a repeat
      if (val_q & source_ready)
         val_d = 1'b0;
      if (pop)
      begin
         val_d = 1'b1;
         // arithmetic engine is out of scope: inverse frames leave swapped
         re_d  = fsi_pkg::fsi_widen(h_inv ? h_im : h_re);
         im_d  = fsi_pkg::fsi_widen(h_inv ? h_re : h_im);
         exp_d = fsi_pkg::EXP_NONE;
         sop_d = head[fsi_pkg::W_SOP];
         eop_d = head[fsi_pkg::W_EOP];
         err_d = head[fsi_pkg::W_ERR_LSB +: fsi_pkg::ERR_W] | chk_err_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         val_q <= 1'b0;
         re_q  <= '0;
         im_q  <= '0;
         exp_q <= fsi_pkg::EXP_NONE;
         sop_q <= 1'b0;
         eop_q <= 1'b0;
         err_q <= fsi_pkg::ERR_NONE;
      end
      else
      begin
         val_q <= val_d;
         re_q  <= re_d;
         im_q  <= im_d;
         exp_q <= exp_d;
         sop_q <= sop_d;
         eop_q <= eop_d;
         err_q <= err_d;
      end
   end

   assign source_valid = val_q;
   assign source_real  = re_q;
   assign source_imag  = im_q;
   assign source_exp   = exp_q;
   assign source_sop   = sop_q;
   assign source_eop   = eop_q;
   assign source_error = err_q;
endmodule // fsi_top

/* File: sim/fsi_chk.sv */
// port assertions for the streaming port logic
`timescale 1ns/1ps
module fsi_chk (
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic                       clk_ena,
   input wire logic                       inverse,
   input wire logic                       sink_valid,
   input wire logic                       sink_ready,
   input wire logic                       sink_sop,
   input wire logic                       sink_eop,
   input wire logic                       source_valid,
   input wire logic                       source_ready,
   input wire logic                       source_sop,
   input wire logic                       source_eop,
   input wire logic [fsi_pkg::DATA_W-1:0] sink_real,
   input wire logic [fsi_pkg::DATA_W-1:0] sink_imag,
   input wire logic [fsi_pkg::ERR_W-1:0]  sink_error,
   input wire logic [fsi_pkg::ERR_W-1:0]  source_error,
   input wire logic [fsi_pkg::OUT_W-1:0]  source_real,
   input wire logic [fsi_pkg::OUT_W-1:0]  source_imag,
   input wire logic [fsi_pkg::EXP_W-1:0]  source_exp
);
   // -----------------------------
   // beats in flight, output position
   // -----------------------------
   logic [5:0] pend_q, pend_d, ocnt_q, ocnt_d;
   always_comb
   begin
      pend_d = pend_q + {5'h00, sink_valid & sink_ready} - {5'h00, source_valid & source_ready};
      ocnt_d = ocnt_q + {5'h00, source_valid & source_ready};
   end
   always_ff @(posedge clk)
   begin
      pend_q <= sys_rst ? 6'h00 : pend_d;
      ocnt_q <= sys_rst ? 6'h00 : ocnt_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_hold_stall: assert property (
      source_valid && !source_ready |=> source_valid && $stable({source_real, source_imag,
      source_exp, source_sop, source_eop, source_error})) else $error("output moved in stall");
   a_exp_zero: assert property (
      source_valid |-> source_exp == fsi_pkg::EXP_NONE) else $error("exponent not zero");
   a_ena_off: assert property (
      !clk_ena [*3] |-> !sink_ready) else $error("ready while disabled");
   a_ready_ena: assert property (
      $rose(sink_ready) |-> $past(clk_ena)) else $error("ready rose without enable");
   a_sop_first: assert property (
      source_valid && source_error == 2'h0 |-> source_sop == (ocnt_q == 6'h00))
      else $error("start marker misplaced");
   a_eop_last: assert property (
      source_valid && source_error == 2'h0 |-> source_eop == (ocnt_q == 6'h3f))
      else $error("end marker misplaced");
   a_valid_owed: assert property (
      source_valid |-> pend_q != 6'h00) else $error("valid with nothing owed");
   a_no_overrun: assert property (
      pend_q <= 6'h11) else $error("more beats taken than stored");
endmodule // fsi_chk

/* File: sim/fsi_sink_model.sv */
// downstream result sink, prompt or slow or stalled
`timescale 1ns/1ps
module fsi_sink_model (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      stall,
   input  wire logic                      slow,
   input  wire logic                      source_valid,
   output      logic                      source_ready,
   input  wire logic [fsi_pkg::OUT_W-1:0] source_real,
   input  wire logic [fsi_pkg::OUT_W-1:0] source_imag,
   input  wire logic                      source_sop,
   input  wire logic                      source_eop,
   input  wire logic [fsi_pkg::ERR_W-1:0] source_error
);
   logic [2*fsi_pkg::OUT_W+3:0] rx[$];
   logic                        ph_q;
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx.delete();
         ph_q <= 1'b0;
         source_ready <= 1'b0;
      end
      else
      begin
         if (source_valid && source_ready)
            rx.push_back({source_error, source_eop, source_sop, source_imag, source_real});
         ph_q <= !ph_q;
         source_ready <= !stall && (!slow || ph_q);
      end
   end
endmodule // fsi_sink_model

/* File: sim/fsi_top_test.sv */
// self-checking bench for the streaming port logic
`timescale 1ns/1ps
module fsi_top_test;
   localparam int PW = 2 * fsi_pkg::OUT_W + 4;
   logic clk, sys_rst, clk_ena, inverse, sink_valid, sink_sop, sink_eop, stall, slow;
   logic sink_ready, source_valid, source_ready, source_sop, source_eop;
   logic [fsi_pkg::DATA_W-1:0] sink_real, sink_imag;
   logic [fsi_pkg::ERR_W-1:0]  sink_error, source_error;
   logic [fsi_pkg::OUT_W-1:0]  source_real, source_imag;
   logic [fsi_pkg::EXP_W-1:0]  source_exp;
   int                         n_fail, checked, cyc, c;
   fsi_top dut (.clk, .sys_rst, .clk_ena, .inverse, .sink_valid, .sink_ready, .sink_real,
      .sink_imag, .sink_sop, .sink_eop, .sink_error, .source_valid, .source_ready,
      .source_real, .source_imag, .source_exp, .source_sop, .source_eop, .source_error);
   fsi_sink_model sk (.clk, .sys_rst, .stall, .slow, .source_valid, .source_ready,
      .source_real, .source_imag, .source_sop, .source_eop, .source_error);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------
   // tasks
   // ------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // timeout well above the longest test sequence
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("[ERR] %0t timeout %h %h", $time, cyc, 0);
         end_sim();
      end
   end
   task automatic chk(input logic [PW-1:0] got, input logic [PW-1:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rst();
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      chk(PW'({sink_ready, source_valid, source_error, source_exp, source_real}), '0);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic push(input logic [15:0] v, input logic s, e, input logic [1:0] er);
      sink_valid <= 1'b1;
      sink_real <= v;
      sink_imag <= ~v;
      sink_sop <= s;
      sink_eop <= e;
      sink_error <= er;
      @(negedge clk);
      while (sink_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic frame(input int n, input logic s, e, input logic [1:0] er, input logic iv);
      int i;
      inverse <= iv;
      for (i = 0; i < n; i++)
      begin
         if (i == 1) inverse <= ~iv;
         push(16'(i * 257 + 32769), s && i == 0, e && i == n - 1, er);
      end
      sink_valid <= 1'b0;
   endtask
   task automatic check_rx(input int n, input logic s, e, input logic [1:0] er, le,
      input logic iv);
      int i;
      logic [fsi_pkg::OUT_W-1:0] v;
      repeat (600) if (sk.rx.size() < n) @(posedge clk);
      chk(PW'(sk.rx.size()), PW'(n));
      for (i = 0; i < n && i < sk.rx.size(); i++)
      begin
         v = fsi_pkg::OUT_W'($signed(16'(i * 257 + 32769)));
         chk(sk.rx[i], {(i == n - 1) ? le : er, e && i == n - 1, s && i == 0,
            iv ? v : ~v, iv ? ~v : v});
      end
   endtask
   // ------------------
   // tests
   // ------------------
   initial
   begin
      {sys_rst, clk_ena, inverse, sink_valid, sink_sop, sink_eop, stall, slow} = 8'hc1;
      {sink_real, sink_imag, sink_error} = '0;
      {n_fail, checked, cyc} = '0;
      for (c = 0; c < 4; c++)
      begin
         rst();
         stall <= c == 2;
         clk_ena <= c != 3;
         fork
            frame(64, 1'b1, 1'b1, 2'h0, c == 1);
            if (c > 1)
            begin
               repeat (60) @(posedge clk);
               chk(PW'({sink_ready, sk.rx.size() != 0}), '0);
               {stall, clk_ena} <= 2'h1;
            end
         join
         check_rx(64, 1'b1, 1'b1, 2'h0, 2'h0, c == 1);
         $display("stream test %0d done", c);
         slow <= 1'b0;
      end
      // missing start, early end, missing end, upstream code passed on
      for (c = 0; c < 4; c++)
      begin
         rst();
         frame(c < 2 ? 1 : 64, c != 0, c[0], c == 3 ? 2'h2 : 2'h0, 1'b0);
         check_rx(c < 2 ? 1 : 64, c != 0, c[0], c == 3 ? 2'h2 : 2'h0,
            8'had >> (2 * c), 1'b0);
         $display("error test %0d done", c);
      end
      end_sim();
   end
endmodule // fsi_top_test
bind fsi_top fsi_chk chk (.clk, .sys_rst, .clk_ena, .inverse, .sink_valid, .sink_ready,
   .sink_sop, .sink_eop, .source_valid, .source_ready, .source_sop, .source_eop, .sink_real,
   .sink_imag, .sink_error, .source_error, .source_real, .source_imag, .source_exp);
